// [rtl/bsf_regs.vh]
`ifndef BSF_REGS_VH
`define BSF_REGS_VH
// fault word bit values
`define BSF_F_MEM 24'h000001
`define BSF_F_PROX1 24'h000002
`define BSF_F_PROX2 24'h000004
`define BSF_F_AIN1_BRK 24'h000008
`define BSF_F_AIN2_BRK 24'h000010
`define BSF_F_AIN3_BRK 24'h000020
`define BSF_F_AIN1_RNG 24'h000040
`define BSF_F_AIN2_RNG 24'h000080
`define BSF_F_AIN3_RNG 24'h000100
`define BSF_F_MIN_FLOW 24'h000400
`define BSF_F_SENSOR 24'h000800
`define BSF_F_REL1 24'h001000
`define BSF_F_REL2 24'h002000
`define BSF_F_OVER 24'h004000
`define BSF_F_OFF 24'h008000
`define BSF_F_PRN 24'h010000
`define BSF_F_PRE_SMALL 24'h020000
`define BSF_F_PRE_LARGE 24'h040000
`define BSF_F_PULSE 24'h080000
// printed as 1048476, which is not a single bit; value kept as printed
`define BSF_F_CONFIRM 24'h0FFF9C
`define BSF_F_PRN_COMM 24'h200000
`define BSF_F_PRN_BUSY 24'h400000
`define BSF_F_PRN_PAPER 24'h800000
// phase masks and current output levels
`define BSF_M_ALWAYS 24'h008001
`define BSF_M_RUN 24'h003FFE
`define BSF_M_FULL_SCALE 16'hFFFF
`define BSF_M_ZERO 16'h0000
// timing at 10 MHz
`define BSF_CLK_HZ 10000000
`define BSF_ALT_MS 1000
`define BSF_RET_MS 4000
// cycle counts for the figures above, sized for the 26-bit interval counter
`define BSF_ALT_CYC 26'h0989680
`define BSF_RET_CYC 26'h2625A00
// lower display selector codes
`define BSF_D_QTY 2'h0
`define BSF_D_FLOW 2'h1
`define BSF_D_TOTAL 2'h2
`define BSF_D_FAULT 2'h3
`endif

// [rtl/bsf_timer.v]
`timescale 1ns/1ps
`include "bsf_regs.vh"
// free or restartable interval counter, single-cycle pulse at terminal count
module bsf_timer #(
  parameter [25:0] LIMIT = 26'h0000010
) (
  input wire mclk,
  input wire reset_n,
  input wire ce,
  input wire restart,
  output reg tick
);
  // 26 bits: the four-second return count does not fit in 24
  reg [25:0] cnt_reg;
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_reg <= 26'h0000000;
      tick <= 1'b0;
    end
    else if (ce)
    begin
      if (restart || cnt_reg == LIMIT - 26'h0000001)
        cnt_reg <= 26'h0000000;
      else
        cnt_reg <= cnt_reg + 26'h0000001;
      tick <= !restart && (cnt_reg == LIMIT - 26'h0000001);
    end
  end
endmodule

// [rtl/bsf_fault.v]
`timescale 1ns/1ps
`include "bsf_regs.vh"
// latched fault word with phase gating
module bsf_fault (
  input wire mclk,
  input wire reset_n,
  input wire ce,
  input wire clear,
  input wire running,
  input wire idle_or_stopped,
  input wire [23:0] fault_in,
  output reg [23:0] fault_reg
);
  reg [23:0] gate;
  always @*
  begin
    gate = `BSF_M_ALWAYS;
    if (running)
      gate = gate | `BSF_M_RUN;
    if (idle_or_stopped)
      gate = gate | `BSF_F_PRN;
    if (idle_or_stopped && !running)
      gate = gate | `BSF_F_OVER;
    gate = gate | `BSF_F_PRE_SMALL | `BSF_F_PRE_LARGE | `BSF_F_PULSE
      | `BSF_F_PRN_COMM | `BSF_F_PRN_BUSY | `BSF_F_PRN_PAPER;
    // confirmation code overlaps phase-gated bits, so only its full pattern opens them;
    // limitation: other faults that together cover the pattern read as confirmation
    if ((fault_in & `BSF_F_CONFIRM) == `BSF_F_CONFIRM)
      gate = gate | `BSF_F_CONFIRM;
  end
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      fault_reg <= 24'h000000;
    else if (ce)
    begin
      // new events win over a simultaneous clear
      if (clear)
        fault_reg <= fault_in & gate;
      else
        fault_reg <= fault_reg | (fault_in & gate);
    end
  end
endmodule

// [rtl/bsf_core.v]
`timescale 1ns/1ps
`include "bsf_regs.vh"
// Overview of operation
// - reset key required before first batch; it clears the stored preset
// - set after reset loads keyed preset and zeroes batched quantity; ready to start
// - start closes shutoff stages, current to full scale, batching indicator on
// - stop key or off input interrupts an active batch at any time
// - after stop key, start resumes batching immediately
// - after off input, start ignored until reset clears the fault
// - set then start begins a new batch with the unchanged preset
// - reset while stopped with no fault latched terminates the batch
// - after supply loss, start resumes the interrupted batch
// - any fault interrupts batching and stays latched until reset
// - fault codes 1 to 256 for memory, proximity, analog breaks and ranges
// - codes 1024, 2048, 4096, 8192 for min flow, sensor, releases
// - codes 16384 over-batch, 32768 off input, 65536 printer
// - codes for preset too small, too large and faulty pulse
// - codes for missing confirmation and printer errors
// - memory and off faults watched in every state
// - codes 2 to 8192 watched only while batching started
// - printer fault watched only before start and after stop
// - over-batching watched only before start and after stop
// - with a fault, lower display alternates fault and quantity every second
// - display key steps flow then totaliser; totaliser idle only; 4 s return except flow view while batching
// - flow view switches to batched quantity when batching starts
// - external stop opens outputs one to three and drops current below live zero
module bsf_core (
  input wire mclk,
  input wire reset_n,
  input wire ce,
  input wire key_reset,
  input wire key_set,
  input wire key_start,
  input wire key_stop,
  input wire key_display,
  input wire off_in,
  input wire ext_stop_in,
  input wire power_restored,
  input wire [31:0] preset_keyed,
  input wire qty_step,
  input wire fault_memory,
  input wire proximity_contact_one_break,
  input wire proximity_contact_two_break,
  input wire [2:0] ain_break,
  input wire [2:0] ain_range,
  input wire min_flow_fault,
  input wire sensor_fault,
  input wire [1:0] release_missing,
  input wire printer_fault,
  input wire preset_small,
  input wire preset_large,
  input wire pulse_fault,
  input wire confirm_missing,
  input wire printer_comm,
  input wire printer_busy,
  input wire printer_paper,
  output reg [2:0] shutoff_reg,
  output reg [15:0] current_reg,
  output reg batching_reg,
  output reg ready_reg,
  output reg [31:0] preset_reg,
  output reg [31:0] batched_reg,
  output reg [23:0] fault_word_reg,
  output reg [1:0] lower_disp_reg
);
  localparam [4:0] ST_LOCK = 5'h01;
  localparam [4:0] ST_READY = 5'h02;
  localparam [4:0] ST_RUN = 5'h04;
  localparam [4:0] ST_STOP = 5'h08;
  localparam [4:0] ST_DONE = 5'h10;

  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [1:0] disp_next;
  wire [23:0] fault_word;
  wire [23:0] fault_in;
  wire fault_any;
  wire interrupt;
  wire alt_tick;
  wire ret_tick;
  wire run_now;

  function [23:0] sel;
    input cond;
    input [23:0] code;
    begin
      sel = cond ? code : 24'h000000;
    end
  endfunction

  assign fault_in = sel(fault_memory, `BSF_F_MEM)
    | sel(proximity_contact_one_break, `BSF_F_PROX1)
    | sel(proximity_contact_two_break, `BSF_F_PROX2)
    | sel(ain_break[0], `BSF_F_AIN1_BRK) | sel(ain_break[1], `BSF_F_AIN2_BRK)
    | sel(ain_break[2], `BSF_F_AIN3_BRK) | sel(ain_range[0], `BSF_F_AIN1_RNG)
    | sel(ain_range[1], `BSF_F_AIN2_RNG) | sel(ain_range[2], `BSF_F_AIN3_RNG)
    | sel(min_flow_fault, `BSF_F_MIN_FLOW) | sel(sensor_fault, `BSF_F_SENSOR)
    | sel(release_missing[0], `BSF_F_REL1) | sel(release_missing[1], `BSF_F_REL2)
    | sel(batched_reg > preset_reg, `BSF_F_OVER)
    | sel(off_in, `BSF_F_OFF) | sel(printer_fault, `BSF_F_PRN)
    | sel(preset_small, `BSF_F_PRE_SMALL) | sel(preset_large, `BSF_F_PRE_LARGE)
    | sel(pulse_fault, `BSF_F_PULSE)
    | sel(confirm_missing, `BSF_F_CONFIRM) | sel(printer_comm, `BSF_F_PRN_COMM)
    | sel(printer_busy, `BSF_F_PRN_BUSY) | sel(printer_paper, `BSF_F_PRN_PAPER);

  assign run_now = (state_reg == ST_RUN);
  assign fault_any = (fault_word != 24'h000000);
  assign interrupt = key_stop || off_in || ext_stop_in || fault_any;

  bsf_fault u_fault (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .clear(key_reset),
    .running(run_now),
    .idle_or_stopped(!run_now),
    .fault_in(fault_in),
    .fault_reg(fault_word)
  );

  bsf_timer #(.LIMIT(`BSF_ALT_CYC)) u_alt (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .restart(!fault_any),
    .tick(alt_tick)
  );

  bsf_timer #(.LIMIT(`BSF_RET_CYC)) u_ret (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .restart(key_display),
    .tick(ret_tick)
  );

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_LOCK:
        if (key_reset && !key_set)
          state_next = ST_DONE;
      ST_DONE:
        if (key_set)
          state_next = ST_READY;
      ST_READY:
        if (key_start && !interrupt)
          state_next = ST_RUN;
      ST_RUN:
        if (interrupt)
          state_next = ST_STOP;
      ST_STOP:
        // with a fault latched, reset only clears it so start can resume
        if (key_reset && fault_any)
          state_next = ST_STOP;
        else if (key_reset)
          state_next = ST_DONE;
        else if (key_set)
          state_next = ST_READY;
        else if (key_start && !interrupt)
          state_next = ST_RUN;
      default:
        state_next = ST_LOCK;
    endcase
  end

  always @*
  begin
    disp_next = lower_disp_reg;
    if (fault_any)
    begin
      if (alt_tick)
        disp_next = (lower_disp_reg == `BSF_D_FAULT) ? `BSF_D_QTY : `BSF_D_FAULT;
    end
    else if (lower_disp_reg == `BSF_D_FAULT)
      disp_next = `BSF_D_QTY;
    else if (state_next == ST_RUN && !run_now && lower_disp_reg != `BSF_D_QTY)
      disp_next = `BSF_D_QTY;
    else if (key_display)
    begin
      if (lower_disp_reg == `BSF_D_QTY)
        disp_next = `BSF_D_FLOW;
      else if (lower_disp_reg == `BSF_D_FLOW && !run_now)
        disp_next = `BSF_D_TOTAL;
      else
        disp_next = `BSF_D_QTY;
    end
    // during batching the flow view stays until changed by hand
    else if (ret_tick && !(run_now && lower_disp_reg == `BSF_D_FLOW))
      disp_next = `BSF_D_QTY;
  end

  // state_reg is held across supply loss by the surrounding retention logic;
  // power_restored moves a running batch to ST_STOP and forces outputs safe, so start is needed again
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= ST_LOCK;
      shutoff_reg <= 3'h0;
      current_reg <= `BSF_M_ZERO;
      batching_reg <= 1'b0;
      ready_reg <= 1'b0;
      preset_reg <= 32'h00000000;
      batched_reg <= 32'h00000000;
      fault_word_reg <= 24'h000000;
      lower_disp_reg <= `BSF_D_QTY;
    end
    else if (ce)
    begin
      state_reg <= (power_restored && run_now) ? ST_STOP : state_next;
      if (state_reg == ST_LOCK && key_reset)
        preset_reg <= 32'h00000000;
      if (key_set && state_next == ST_READY)
      begin
        if (state_reg == ST_DONE)
          preset_reg <= preset_keyed;
        batched_reg <= 32'h00000000;
      end
      else if (run_now && qty_step)
        batched_reg <= batched_reg + 32'h00000001;
      if (ext_stop_in || off_in || state_next != ST_RUN || power_restored)
      begin
        shutoff_reg <= 3'h0;
        current_reg <= `BSF_M_ZERO;
        batching_reg <= 1'b0;
      end
      else
      begin
        shutoff_reg <= 3'h7;
        current_reg <= `BSF_M_FULL_SCALE;
        batching_reg <= 1'b1;
      end
      ready_reg <= (state_next == ST_READY);
      fault_word_reg <= fault_word;
      lower_disp_reg <= disp_next;
    end
  end
endmodule

// [tb/bsf_chk_properties.sv]
`timescale 1ns/1ps
`include "bsf_regs.vh"
module bsf_chk (
  input logic mclk,
  input logic reset_n,
  input logic key_set,
  input logic key_reset,
  input logic key_stop,
  input logic off_in,
  input logic ext_stop_in,
  input logic [31:0] preset_keyed,
  input logic [2:0] shutoff_reg,
  input logic [15:0] current_reg,
  input logic batching_reg,
  input logic ready_reg,
  input logic [31:0] preset_reg,
  input logic [31:0] batched_reg,
  input logic [23:0] fault_word_reg,
  input logic [1:0] lower_disp_reg
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  sequence s_set_ready;
    key_set && !batching_reg ##1 ready_reg;
  endsequence
  sequence s_halt_req;
    batching_reg && (key_stop || off_in);
  endsequence
  a_start_outs: assert property ($rose(batching_reg) |->
    shutoff_reg == 3'h7 && current_reg == `BSF_M_FULL_SCALE) else $error("start outputs wrong");
  a_set_load: assert property (s_set_ready |->
    batched_reg == 32'h0 && preset_reg == $past(preset_keyed)) else $error("set load wrong");
  a_halt_now: assert property (s_halt_req |=>
    !batching_reg && shutoff_reg == 3'h0) else $error("batch not halted");
  a_ext_outs: assert property (ext_stop_in |=>
    shutoff_reg == 3'h0 && current_reg == `BSF_M_ZERO) else $error("ext stop outputs");
  a_off_latch: assert property (off_in && !key_reset ##1 !key_reset |->
    ##1 fault_word_reg[15]) else $error("off fault missing");
  a_fault_keep: assert property ($past(!key_reset, 2) |->
    (fault_word_reg & $past(fault_word_reg)) == $past(fault_word_reg)) else $error("fault lost");
  a_fault_halt: assert property (fault_word_reg != 24'h0 |->
    ##[0:1] !batching_reg) else $error("fault did not halt");
  a_flow_view: assert property ($rose(batching_reg) |->
    lower_disp_reg != `BSF_D_FLOW) else $error("flow view kept");
  a_start_block: assert property (off_in || ext_stop_in |=>
    !$rose(batching_reg)) else $error("start not refused");
endmodule

// [tb/bsf_flow_plant.sv]
`timescale 1ns/1ps
// flow meter: a quantity pulse every fourth cycle while all stages are closed
module bsf_flow_plant (
  input logic mclk,
  input logic [2:0] shutoff_reg,
  output logic qty_step
);
  logic [1:0] ph = 2'h0;
  initial qty_step = 1'b0;
  always @(posedge mclk)
  begin
    ph <= #1 ph + 2'h1;
    qty_step <= #1 (shutoff_reg == 3'h7) && (ph == 2'h3);
  end
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
`include "bsf_regs.vh"
module tb_top;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic off_in = 1'b0;
  logic ext_stop_in = 1'b0;
  logic [5:0] keys = 6'h00;
  logic [23:0] fin = 24'h000000;
  // large preset so the plant never over-batches until t_faults keys a preset of 2
  logic [31:0] preset_keyed = 32'h00010000;
  logic qty_step;
  logic [2:0] shutoff_reg;
  logic [15:0] current_reg;
  logic batching_reg;
  logic ready_reg;
  logic [31:0] preset_reg;
  logic [31:0] batched_reg;
  logic [23:0] fault_word_reg;
  logic [1:0] lower_disp_reg;
  int err_total = 0;
  int n_checks = 0;
  always #50 mclk = ~mclk;
  bsf_core bsf_core_i (.mclk(mclk), .reset_n(reset_n), .ce(1'b1), .key_reset(keys[0]),
    .key_set(keys[1]), .key_start(keys[2]), .key_stop(keys[3]), .key_display(keys[4]),
    .off_in(off_in), .ext_stop_in(ext_stop_in), .power_restored(keys[5]),
    .preset_keyed(preset_keyed), .qty_step(qty_step), .fault_memory(fin[0]),
    .proximity_contact_one_break(fin[1]), .proximity_contact_two_break(fin[2]),
    .ain_break(fin[5:3]), .ain_range(fin[8:6]), .min_flow_fault(fin[10]),
    .sensor_fault(fin[11]), .release_missing(fin[13:12]), .printer_fault(fin[16]),
    .preset_small(fin[17]), .preset_large(fin[18]), .pulse_fault(fin[19]),
    .confirm_missing(fin[20]), .printer_comm(fin[21]), .printer_busy(fin[22]),
    .printer_paper(fin[23]), .shutoff_reg(shutoff_reg), .current_reg(current_reg),
    .batching_reg(batching_reg), .ready_reg(ready_reg), .preset_reg(preset_reg),
    .batched_reg(batched_reg), .fault_word_reg(fault_word_reg),
    .lower_disp_reg(lower_disp_reg));
  bsf_flow_plant bsf_flow_plant_i (.mclk(mclk), .shutoff_reg(shutoff_reg), .qty_step(qty_step));
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // one-cycle pulse; index 5 is the supply-return pulse
  task press(input int k);
    @(posedge mclk);
    #1 keys = 6'h01 << k;
    @(posedge mclk);
    #1 keys = 6'h00;
  endtask
  task arm;
    press(0);
    press(1);
    press(2);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task t_first;
    int i;
    press(2);
    chk("batching", batching_reg, 1'b0);
    press(0);
    press(1);
    chk("preset", preset_reg, preset_keyed);
    chk("batched", batched_reg, 32'h0);
    chk("ready", ready_reg, 1'b1);
    press(4);
    chk("display", lower_disp_reg, `BSF_D_FLOW);
    press(2);
    chk("shutoff", shutoff_reg, 3'h7);
    chk("current", current_reg, `BSF_M_FULL_SCALE);
    chk("batching", batching_reg, 1'b1);
    chk("display", lower_disp_reg, `BSF_D_QTY);
    for (i = 0; i < 100 && batched_reg < 32'h2; i++)
      cyc(1);
    chk("counting", batched_reg >= 32'h2, 1'b1);
  endtask
  task t_resume;
    press(3);
    chk("batching", batching_reg, 1'b0);
    chk("shutoff", shutoff_reg, 3'h0);
    press(2);
    chk("batching", batching_reg, 1'b1);
    press(5);
    chk("batching", batching_reg, 1'b0);
    press(2);
    chk("batching", batching_reg, 1'b1);
  endtask
  task t_off;
    off_in = 1'b1;
    cyc(2);
    chk("batching", batching_reg, 1'b0);
    chk("fault", fault_word_reg, `BSF_F_OFF);
    off_in = 1'b0;
    press(2);
    chk("batching", batching_reg, 1'b0);
    press(0);
    cyc(2);
    chk("fault", fault_word_reg, 24'h0);
    press(2);
    chk("batching", batching_reg, 1'b1);
  endtask
  task t_terminate;
    press(3);
    press(1);
    chk("batched", batched_reg, 32'h0);
    press(2);
    chk("batching", batching_reg, 1'b1);
    press(3);
    press(0);
    // terminating keeps the preset; only the first reset clears it
    chk("preset", preset_reg, preset_keyed);
    press(2);
    chk("batching", batching_reg, 1'b0);
    press(4);
    press(4);
    chk("display", lower_disp_reg, `BSF_D_TOTAL);
  endtask
  task t_faults;
    int i;
    arm;
    chk("display", lower_disp_reg, `BSF_D_QTY);
    ext_stop_in = 1'b1;
    cyc(2);
    chk("shutoff", shutoff_reg, 3'h0);
    chk("current", current_reg, `BSF_M_ZERO);
    ext_stop_in = 1'b0;
    arm;
    fin = 24'h003DFE;
    cyc(2);
    chk("fault", fault_word_reg, 24'h003DFE);
    chk("batching", batching_reg, 1'b0);
    fin = 24'h0;
    press(0);
    press(1);
    fin = 24'h013DFE;
    cyc(2);
    chk("fault", fault_word_reg, `BSF_F_PRN);
    fin = 24'hFE0001;
    press(0);
    cyc(2);
    chk("fault", fault_word_reg, 24'hEFFF9D);
    fin = 24'h0;
    press(0);
    // small preset so the plant over-batches; the fault may only appear after stop
    press(2);
    press(3);
    press(0);
    preset_keyed = 32'h00000002;
    press(1);
    chk("preset", preset_reg, 32'h00000002);
    press(2);
    for (i = 0; i < 40 && batched_reg < 32'h3; i++)
      cyc(1);
    chk("fault", fault_word_reg, 24'h0);
    press(3);
    cyc(2);
    chk("fault", fault_word_reg, `BSF_F_OVER);
  endtask
  initial
  begin
    repeat (12) @(posedge mclk);
    #1 reset_n = 1'b1;
    t_first;
    t_resume;
    t_off;
    t_terminate;
    t_faults;
    end_of_test;
  end
  initial
  begin
    repeat (100000) @(posedge mclk);
    err_total++;
    end_of_test;
  end
endmodule
bind bsf_core bsf_chk bsf_chk_i (.mclk(mclk), .reset_n(reset_n), .key_set(key_set),
  .key_reset(key_reset), .key_stop(key_stop), .off_in(off_in), .ext_stop_in(ext_stop_in),
  .preset_keyed(preset_keyed), .shutoff_reg(shutoff_reg), .current_reg(current_reg),
  .batching_reg(batching_reg), .ready_reg(ready_reg), .preset_reg(preset_reg),
  .batched_reg(batched_reg), .fault_word_reg(fault_word_reg), .lower_disp_reg(lower_disp_reg));
